// ==== hw/efcf_client_fifos.v ====
// receive and transmit frame fifos sitting between user logic and the ethernet mac
`timescale 1ns/1ps
`include "efcf_regs.vh"

// one frame-oriented store; TX_MODE selects transmit behaviour, else receive
module efcf_frame_store #(
  parameter FIFO_SIZE = `EFCF_FIFO_SIZE,
  parameter DATA_W    = `EFCF_DATA_W,
  parameter TX_MODE   = 0
) (
  input  wire              core_clk_i,
  input  wire              resetn_i,
  input  wire [DATA_W-1:0] in_tdata_i,
  input  wire              in_tvalid_i,
  input  wire              in_tlast_i,
  input  wire              in_tuser_i,
  output wire              in_tready_o,
  output wire [DATA_W-1:0] out_tdata_o,
  output wire              out_tvalid_o,
  output wire              out_tlast_o,
  input  wire              out_tready_i,
  output wire              overflow_o
);

  localparam AW = $clog2(FIFO_SIZE);
  localparam [31:0] SIZE_WORD = FIFO_SIZE;
  localparam [AW:0] FULL_CNT  = SIZE_WORD[AW:0];
  localparam [AW:0] ONE       = {{AW{1'b0}}, 1'b1};

  reg [DATA_W:0]   mem_reg [0:FIFO_SIZE-1];
  reg [AW:0]       wr_cur_reg;
  reg [AW:0]       wr_cur_next;
  reg [AW:0]       wr_commit_reg;
  reg [AW:0]       wr_commit_next;
  reg [AW:0]       rd_ptr_reg;
  reg [AW:0]       rd_ptr_next;
  reg              drop_reg;
  reg              drop_next;
  reg              ready_reg;
  reg              ready_next;
  reg              ovf_reg;
  reg              ovf_next;
  reg              out_valid_reg;
  reg              out_valid_next;
  reg [DATA_W-1:0] out_data_reg;
  reg [DATA_W-1:0] out_data_next;
  reg              out_last_reg;
  reg              out_last_next;
  reg              mem_we;

  wire          accept   = in_tvalid_i & ready_reg;
  wire [AW:0]   used     = wr_cur_reg - rd_ptr_reg;
  wire          full     = (used == FULL_CNT);
  wire [AW:0]   full_chk = wr_cur_next - rd_ptr_next;

  always @* begin
    wr_cur_next    = wr_cur_reg;
    wr_commit_next = wr_commit_reg;
    drop_next      = drop_reg;
    ovf_next       = 1'b0;
    mem_we         = 1'b0;
    if (accept) begin
      if (drop_reg) begin
        // swallow the rest of a dropped frame, rewind on its last beat
        if (in_tlast_i) begin
          drop_next   = 1'b0;
          wr_cur_next = wr_commit_reg;
        end
      end else if (full) begin
        // storage ran out inside a frame: flag it and drop the whole frame
        ovf_next = 1'b1;
        if (in_tlast_i) begin
          wr_cur_next = wr_commit_reg;
        end else begin
          drop_next = 1'b1;
        end
      end else begin
        mem_we = 1'b1;
        if (in_tlast_i) begin
          // frame end: in receive mode bad frames rewind, every other frame becomes readable
          if (TX_MODE == 0 && in_tuser_i) begin
            wr_cur_next = wr_commit_reg;
          end else begin
            wr_cur_next    = wr_cur_reg + ONE;
            wr_commit_next = wr_cur_reg + ONE;
          end
        end else begin
          wr_cur_next = wr_cur_reg + ONE;
        end
      end
    end
  end

  always @* begin
    rd_ptr_next    = rd_ptr_reg;
    out_valid_next = out_valid_reg;
    out_data_next  = out_data_reg;
    out_last_next  = out_last_reg;
    // beat held stable until the sink takes it
    if (!out_valid_reg || out_tready_i) begin
      // only committed, complete frames are read out
      if (rd_ptr_reg != wr_commit_reg) begin
        out_valid_next = 1'b1;
        out_data_next  = mem_reg[rd_ptr_reg[AW-1:0]][DATA_W-1:0];
        out_last_next  = mem_reg[rd_ptr_reg[AW-1:0]][DATA_W];
        rd_ptr_next    = rd_ptr_reg + ONE;
      end else begin
        out_valid_next = 1'b0;
      end
    end
  end

  always @* begin
    if (TX_MODE == 0) begin
      ready_next = 1'b1;
    end else begin
      // stall writers while full unless a frame is being dropped or no whole frame is held
      ready_next = (full_chk != FULL_CNT) || drop_next || (wr_commit_next == rd_ptr_next);
    end
  end

  always @(posedge core_clk_i) begin
    if (mem_we) begin
      mem_reg[wr_cur_reg[AW-1:0]] <= {in_tlast_i, in_tdata_i};
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_cur_reg    <= {(AW+1){1'b0}};
      wr_commit_reg <= {(AW+1){1'b0}};
      rd_ptr_reg    <= {(AW+1){1'b0}};
      drop_reg      <= 1'b0;
      ready_reg     <= 1'b0;
      ovf_reg       <= 1'b0;
      out_valid_reg <= 1'b0;
      out_data_reg  <= {DATA_W{1'b0}};
      out_last_reg  <= 1'b0;
    end else begin
      wr_cur_reg    <= wr_cur_next;
      wr_commit_reg <= wr_commit_next;
      rd_ptr_reg    <= rd_ptr_next;
      drop_reg      <= drop_next;
      ready_reg     <= ready_next;
      ovf_reg       <= ovf_next;
      out_valid_reg <= out_valid_next;
      out_data_reg  <= out_data_next;
      out_last_reg  <= out_last_next;
    end
  end

  assign in_tready_o  = ready_reg;
  assign out_tdata_o  = out_data_reg;
  assign out_tvalid_o = out_valid_reg;
  assign out_tlast_o  = out_last_reg;
  assign overflow_o   = ovf_reg;

endmodule // efcf_frame_store

module efcf_client_fifos #(
  parameter FIFO_SIZE = `EFCF_FIFO_SIZE,
  parameter DATA_W    = `EFCF_DATA_W
) (
  input  wire              core_clk_i,
  input  wire              resetn_i,
  input  wire [DATA_W-1:0] rx_mac_tdata_i,
  input  wire              rx_mac_tvalid_i,
  input  wire              rx_mac_tlast_i,
  input  wire              rx_mac_tuser_i,
  output wire [DATA_W-1:0] rx_fifo_tdata_o,
  output wire              rx_fifo_tvalid_o,
  output wire              rx_fifo_tlast_o,
  input  wire              rx_fifo_tready_i,
  output wire              rx_overflow_o,
  input  wire [DATA_W-1:0] tx_fifo_tdata_i,
  input  wire              tx_fifo_tvalid_i,
  input  wire              tx_fifo_tlast_i,
  output wire              tx_fifo_tready_o,
  output wire [DATA_W-1:0] tx_mac_tdata_o,
  output wire              tx_mac_tvalid_o,
  output wire              tx_mac_tlast_o,
  input  wire              tx_mac_tready_i,
  output wire              tx_overflow_o
);

  // the mac receiver cannot be stalled, so its ready is not used
  efcf_frame_store #(
    .FIFO_SIZE (FIFO_SIZE),
    .DATA_W    (DATA_W),
    .TX_MODE   (0)
  ) u_rx (
    .core_clk_i   (core_clk_i),
    .resetn_i     (resetn_i),
    .in_tdata_i   (rx_mac_tdata_i),
    .in_tvalid_i  (rx_mac_tvalid_i),
    .in_tlast_i   (rx_mac_tlast_i),
    .in_tuser_i   (rx_mac_tuser_i),
    .in_tready_o  (),
    .out_tdata_o  (rx_fifo_tdata_o),
    .out_tvalid_o (rx_fifo_tvalid_o),
    .out_tlast_o  (rx_fifo_tlast_o),
    .out_tready_i (rx_fifo_tready_i),
    .overflow_o   (rx_overflow_o)
  );

  efcf_frame_store #(
    .FIFO_SIZE (FIFO_SIZE),
    .DATA_W    (DATA_W),
    .TX_MODE   (1)
  ) u_tx (
    .core_clk_i   (core_clk_i),
    .resetn_i     (resetn_i),
    .in_tdata_i   (tx_fifo_tdata_i),
    .in_tvalid_i  (tx_fifo_tvalid_i),
    .in_tlast_i   (tx_fifo_tlast_i),
    .in_tuser_i   (1'b0),
    .in_tready_o  (tx_fifo_tready_o),
    .out_tdata_o  (tx_mac_tdata_o),
    .out_tvalid_o (tx_mac_tvalid_o),
    .out_tlast_o  (tx_mac_tlast_o),
    .out_tready_i (tx_mac_tready_i),
    .overflow_o   (tx_overflow_o)
  );

endmodule // efcf_client_fifos

// ==== common/efcf_regs.vh ====
// constants for the ethernet client frame fifos
`ifndef EFCF_REGS_VH
`define EFCF_REGS_VH

// default storage depth in bytes, one byte per beat
`define EFCF_FIFO_SIZE     32'h0000_0400
// largest storage depth the design is meant to support
`define EFCF_FIFO_SIZE_MAX 32'h0000_4000
// stream data width in bits
`define EFCF_DATA_W        32'h0000_0008

`endif

// ==== verification/efcf_props.sv ====
// assertion checker for the client frame fifos
`timescale 1ns/1ps
module efcf_props #(parameter DATA_W = 8) (
  input wire logic core_clk_i, resetn_i, rx_mac_tvalid_i, rx_mac_tlast_i, rx_mac_tuser_i,
  input wire logic [DATA_W-1:0] rx_fifo_tdata_o, tx_mac_tdata_o,
  input wire logic rx_fifo_tvalid_o, rx_fifo_tready_i, rx_overflow_o, tx_fifo_tvalid_i,
  input wire logic tx_fifo_tlast_i, tx_fifo_tready_o, tx_mac_tvalid_o, tx_mac_tready_i,
  input wire logic tx_overflow_o
);
  logic good_reg;
  logic done_reg;
  always @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i) {good_reg, done_reg} <= 2'b00;
    else {good_reg, done_reg} <= {good_reg | rx_mac_tvalid_i & rx_mac_tlast_i & !rx_mac_tuser_i,
      done_reg | tx_fifo_tvalid_i & tx_fifo_tready_o & tx_fifo_tlast_i};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence rx_stall_s; rx_fifo_tvalid_o && !rx_fifo_tready_i; endsequence
  sequence tx_stall_s; tx_mac_tvalid_o && !tx_mac_tready_i; endsequence
  sequence tx_after_s; tx_fifo_tready_o ##1 tx_fifo_tready_o && !tx_overflow_o; endsequence
  rx_beat_hold_a: assert property (rx_stall_s |=>
    rx_fifo_tvalid_o && $stable(rx_fifo_tdata_o)) else $error("rx beat changed while stalled");
  tx_beat_hold_a: assert property (tx_stall_s |=>
    tx_mac_tvalid_o && $stable(tx_mac_tdata_o)) else $error("tx beat changed while stalled");
  rx_ovf_pulse_a: assert property (rx_overflow_o |=> !rx_overflow_o)
    else $error("rx overflow longer than one cycle");
  rx_ovf_cause_a: assert property (rx_overflow_o |-> $past(rx_mac_tvalid_i))
    else $error("rx overflow without a beat");
  tx_ovf_flow_a: assert property (tx_overflow_o |-> tx_after_s)
    else $error("tx overflow stalled the writer");
  rx_good_first_a: assert property (rx_fifo_tvalid_o |-> $past(good_reg))
    else $error("rx data before any good frame ended");
  tx_whole_first_a: assert property (tx_mac_tvalid_o |-> $past(done_reg))
    else $error("tx data before any whole frame");
  tx_stall_why_a: assert property ($fell(tx_fifo_tready_o) |-> done_reg)
    else $error("tx ready dropped with no whole frame");
endmodule // efcf_props
bind efcf_client_fifos efcf_props #(.DATA_W(DATA_W)) i_props (.*);

// ==== verification/efcf_mac_model.sv ====
// stand-in for the ethernet mac: frame source and transmit sink
`timescale 1ns/1ps
module efcf_mac_model (
  input wire logic core_clk_i, hold_i,
  output logic [7:0] rx_tdata_o,
  output logic rx_tvalid_o, rx_tlast_o, rx_tuser_o,
  input wire logic [7:0] tx_tdata_i,
  input wire logic tx_tvalid_i, tx_tlast_i,
  output logic tx_tready_o
);
  logic [7:0] txq[$], txl[$];
  initial {rx_tdata_o, rx_tvalid_o, rx_tlast_o, rx_tuser_o} = '0;
  assign tx_tready_o = !hold_i;
  always @(posedge core_clk_i) if (tx_tvalid_i === 1'b1 && tx_tready_o) txq.push_back(tx_tdata_i);
  // last beats of transmitted frames, to check frame boundaries
  always @(posedge core_clk_i)
    if (tx_tvalid_i === 1'b1 && tx_tready_o && tx_tlast_i === 1'b1) txl.push_back(tx_tdata_i);
  task send(input int n, input logic [7:0] b, input logic bad);
    for (int i = 0; i < n; i++) begin
      rx_tvalid_o <= 1;
      rx_tdata_o <= b + i[7:0];
      rx_tlast_o <= i == n - 1;
      rx_tuser_o <= bad && i == n - 1;
      @(posedge core_clk_i);
    end
    {rx_tvalid_o, rx_tlast_o, rx_tuser_o} <= 3'b000;
    rx_tdata_o <= ~rx_tdata_o; // idle data never repeats
    @(posedge core_clk_i);
  endtask
endmodule // efcf_mac_model

// ==== verification/tb.sv ====
// self-checking bench for the client frame fifos
`timescale 1ns/1ps
module tb;
  localparam int D = 16;
  logic core_clk_i = 0, resetn_i = 0, rx_fifo_tready_i = 0, hold = 1, tx_mac_tready_i;
  logic tx_fifo_tvalid_i = 0, tx_fifo_tlast_i = 0, rx_mac_tvalid_i, rx_mac_tlast_i;
  logic [7:0] tx_fifo_tdata_i = 0, rx_mac_tdata_i, rx_fifo_tdata_o, tx_mac_tdata_o;
  logic rx_mac_tuser_i, rx_fifo_tvalid_o, rx_fifo_tlast_o, rx_overflow_o;
  logic tx_fifo_tready_o, tx_mac_tvalid_o, tx_mac_tlast_o, tx_overflow_o;
  int errors = 0, checked = 0, cyc = 0, rxo = 0, txo = 0;
  logic [7:0] rxq[$], rxl[$];
  always #12.5 core_clk_i = ~core_clk_i;
  efcf_client_fifos #(.FIFO_SIZE(D)) i_dut (.*);
  efcf_mac_model i_mac (.core_clk_i, .hold_i(hold), .rx_tdata_o(rx_mac_tdata_i),
    .rx_tvalid_o(rx_mac_tvalid_i), .rx_tlast_o(rx_mac_tlast_i), .rx_tuser_o(rx_mac_tuser_i),
    .tx_tdata_i(tx_mac_tdata_o), .tx_tvalid_i(tx_mac_tvalid_o), .tx_tlast_i(tx_mac_tlast_o),
    .tx_tready_o(tx_mac_tready_i));
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    rx_fifo_tready_i <= ~rx_fifo_tready_i;
    if (rx_fifo_tvalid_o === 1'b1 && rx_fifo_tready_i) rxq.push_back(rx_fifo_tdata_o);
    if (rx_fifo_tvalid_o === 1'b1 && rx_fifo_tready_i && rx_fifo_tlast_o === 1'b1)
      rxl.push_back(rx_fifo_tdata_o);
    rxo <= rxo + (rx_overflow_o === 1'b1);
    txo <= txo + (tx_overflow_o === 1'b1);
    if (cyc == 5000) begin
      errors++;
      end_sim();
    end
  end
  task chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic ramp(string n, ref logic [7:0] q[$], input int b, k, c, m);
    chk(n, k + m, q.size());
    for (int i = 0; i < q.size(); i++) chk(n, i < k ? b + i : c + i - k, q[i]);
    q.delete();
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wr(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      tx_fifo_tvalid_i <= 1;
      tx_fifo_tdata_i <= b + i[7:0];
      tx_fifo_tlast_i <= i == n - 1;
      @(posedge core_clk_i);
      while (tx_fifo_tready_o !== 1'b1) @(posedge core_clk_i);
    end
    tx_fifo_tvalid_i <= 0;
  endtask
  task t_rx();
    i_mac.send(4, 8'h10, 0);
    i_mac.send(3, 8'h20, 1);
    i_mac.send(5, 8'h30, 0);
    i_mac.send(D + 4, 8'h40, 0); // oversize on purpose
    repeat (60) @(posedge core_clk_i);
    ramp("rx data", rxq, 'h10, 4, 'h30, 5);
    ramp("rx last", rxl, 'h13, 1, 'h34, 1);
    chk("rx overflow", 1, rxo);
    $display("rx frames done");
  endtask
  task t_tx();
    wr(10, 8'h60);
    chk("tx early valid", 0, tx_mac_tvalid_o);
    @(posedge core_clk_i);
    fork
      wr(10, 8'h70);
      begin
        repeat (30) @(posedge core_clk_i);
        chk("tx full", 'h160, {tx_fifo_tready_o, tx_mac_tvalid_o, tx_mac_tdata_o});
        hold <= 0;
      end
    join
    repeat (40) @(posedge core_clk_i);
    ramp("tx frames", i_mac.txq, 'h60, 10, 'h70, 10);
    ramp("tx last", i_mac.txl, 'h69, 1, 'h79, 1);
    wr(D + 4, 8'h80);
    repeat (20) @(posedge core_clk_i);
    chk("tx overflow", 1, txo);
    chk("tx dropped", 0, i_mac.txq.size());
    chk("tx dropped last", 0, i_mac.txl.size());
    $display("tx frames done");
  endtask
  initial begin
    repeat (8) @(posedge core_clk_i);
    resetn_i <= 1;
    repeat (3) @(posedge core_clk_i);
    t_rx();
    t_tx();
    end_sim();
  end
endmodule // tb
